// ### shared/tks_pkg.sv
package tks_pkg;

  // special function register addresses
  localparam logic [7:0] ADDR_INT_FLAGS   = 8'h95;
  localparam logic [7:0] ADDR_SCAN_STATUS = 8'hab;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'hac;
  localparam logic [7:0] ADDR_TOUCH_CTRL  = 8'had;
  localparam logic [7:0] ADDR_SCAN_CTRL   = 8'hae;
  localparam logic [7:0] ADDR_THRESH_CH0  = 8'hc4;
  localparam logic [7:0] ADDR_THRESH_CH1  = 8'hc5;
  localparam logic [7:0] ADDR_THRESH_CH2  = 8'hc6;
  localparam logic [7:0] ADDR_THRESH_CH3  = 8'hc7;
  localparam logic [7:0] ADDR_AUX_CTRL    = 8'hf8;

  // values after reset
  localparam logic [7:0] RST_TOUCH_CTRL   = 8'hcf;
  localparam logic [3:0] RST_SCAN_CTRL    = 4'h3;
  localparam logic [7:0] RST_THRESH       = 8'h40;
  localparam logic [4:0] RST_AUX_CTRL     = 5'h00;
  localparam logic       RST_DONE_FLAG    = 1'b1;

  // field positions
  localparam int TC_PD_BIT      = 7;  // sense_power_down
  localparam int TC_TMR_LSB     = 4;  // conversion_time_field, 3 bits
  localparam int TC_CHS_LSB     = 0;  // channel_select_field, 4 bits
  localparam int SC_AUTO_BIT    = 3;  // auto_scan_enable
  localparam int SC_RATE_BIT    = 2;  // scan_rate_bit
  localparam int SC_NUM_LSB     = 0;  // scan_channel_count, 2 bits
  localparam int AUX_SOC_BIT    = 4;  // conversion_start_bit
  localparam int IF_TOUCH_BIT   = 3;  // touch_interrupt_flag

  // channel counts and codes
  localparam int              SENSE_CHANNELS = 15;
  localparam int              AUTO_CHANNELS  = 4;
  localparam logic [3:0]      CHS_REF_CAP    = 4'hf;

  // counter widths
  localparam int              COUNT_W        = 10;
  localparam logic [9:0]      COUNT_MAX      = 10'h3ff;

  // measurement window: (time field + 1) << WIN_SHIFT system clock cycles
  localparam int              WIN_SHIFT      = 8;

  // auto-scan period in slow clock cycles
  localparam int              SCAN_LONG_SLOW  = 4096;
  localparam int              SCAN_SHORT_SLOW = 2048;

  // sequencer states, gray coded along idle, measure, compare, gap
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEAS = 2'b01,
    ST_CMP  = 2'b11,
    ST_GAP  = 2'b10
  } tks_state_t;

endpackage : tks_pkg

// ### design/tks_meas.sv
// one conversion: counts pad oscillator pulses inside a timed window
module tks_meas
  import tks_pkg::*;
(
  input  wire logic               sys_clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               start_in,      // one-cycle start pulse
  input  wire logic               abort_in,      // drop a running window
  input  wire logic [2:0]         time_sel_in,   // window length code
  input  wire logic               osc_pulse_in,  // one pulse per pad oscillation
  output logic                    busy_out,
  output logic                    done_out,      // one cycle at window end
  output logic [COUNT_W-1:0]      count_out,
  output logic                    ovf_out
);

  logic [11:0]        win_q;    // cycles left in the window
  logic               busy_q;
  logic               done_q;
  logic [COUNT_W-1:0] cnt_q;
  logic               ovf_q;
  logic [11:0]        win_len;  // window length minus one

  // longer code, longer window, count scales linearly with it
  assign win_len = {({1'b0, time_sel_in} + 4'd1), 8'h00} - 12'd1; // [RULE_09]

  // window timer and pulse counter
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      win_q  <= 12'h000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q  <= '0;
      ovf_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (abort_in) begin
        busy_q <= 1'b0;
      end else if (start_in) begin
        win_q  <= win_len;
        busy_q <= 1'b1;
        cnt_q  <= '0;
        ovf_q  <= 1'b0;
      end else if (busy_q) begin
        // bigger pad capacitance oscillates slower, so fewer pulses
        if (osc_pulse_in) begin
          if (cnt_q == COUNT_MAX) begin
            ovf_q <= 1'b1; // [RULE_08]
          end else begin
            cnt_q <= cnt_q + 10'd1; // [RULE_06]
          end
        end
        if (win_q == 12'h000) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          win_q <= win_q - 12'd1;
        end
      end
    end
  end

  assign busy_out  = busy_q;
  assign done_out  = done_q;
  assign count_out = cnt_q;
  assign ovf_out   = ovf_q;

endmodule : tks_meas

// ### design/tks_ctrl.sv
// What this block does
// [RULE_01] fifteen channels, manual or auto, never both
// [RULE_02] pull-up off on the pin being measured
// [RULE_03] software clears auto and power-down first
// [RULE_04] start bit rising edge begins manual conversion
// [RULE_05] done flag low while running; 10-bit count
// [RULE_06] more pad capacitance gives smaller count
// [RULE_07] software waits 10 us between conversions
// [RULE_08] overflow flag when conversion exceeds its period
// [RULE_09] 3-bit time field sets window length
// [RULE_10] 4-bit channel select, code 15 reference cap
// [RULE_11] auto-scan on channels 0-3, all run modes
// [RULE_12] auto enable hands unit to hardware
// [RULE_13] scan rate bit: 4096 or 2048 slow cycles
// [RULE_14] channel-count field picks channels 0..n
// [RULE_15] count below threshold raises interrupt, wakes cpu
// [RULE_16] result field: one touch bit per channel
// [RULE_17] flag cleared on service entry or F7h write
// [RULE_18] software rechecks touches in manual mode
// [RULE_19] software sets pin modes 0 and 3
// [RULE_20] channels in turn, bits updated after compare
module tks_ctrl
  import tks_pkg::*;
#(
  parameter int SCAN_LONG  = SCAN_LONG_SLOW,  // slow ticks per long period
  parameter int SCAN_SHORT = SCAN_SHORT_SLOW  // slow ticks per short period
) (
  input  wire logic                      sys_clk_in,
  input  wire logic                      rst_n_in,
  input  wire logic [7:0]                sfr_addr_in,
  input  wire logic                      sfr_wr_in,
  input  wire logic                      sfr_rd_in,
  input  wire logic [7:0]                sfr_wdata_in,
  output logic      [7:0]                sfr_rdata_out,
  input  wire logic                      slow_tick_in,
  input  wire logic                      irq_ack_in,
  input  wire logic                      sense_osc_pulse_in,
  output logic      [3:0]                sense_sel_out,
  output logic                           ref_cap_sel_out,
  output logic                           sense_run_out,
  output logic      [SENSE_CHANNELS-1:0] pullup_off_out,
  output logic                           touch_irq_out,
  output logic                           wake_out,
  output logic      [3:0]                aux_misc_out
);

  // register file
  logic [7:0]  touch_ctrl_q;         // power-down, time field, channel select
  logic [3:0]  scan_ctrl_q;          // auto enable, rate, channel count
  logic [7:0]  thresh_q [AUTO_CHANNELS]; // per-channel touch thresholds
  logic [4:0]  aux_q;                // start bit plus unrelated aux bits
  logic        soc_prev_q;           // start bit one cycle ago
  logic        done_flag_q;          // conversion_done_flag
  logic        ovf_flag_q;           // count_overflow_flag
  logic [9:0]  count_q;              // held manual result
  logic [3:0]  result_q;             // auto_scan_result
  logic        touch_flag_q;         // touch_interrupt_flag
  logic [7:0]  rdata_q;
  logic        wake_q;

  // sequencer
  // one gap cycle separates channels of one scan
  tks_state_t  state_q;
  tks_state_t  state_d;
  logic        auto_run_q;           // current conversion belongs to auto-scan
  logic [1:0]  chan_q;               // auto-scan channel in turn
  logic [12:0] period_q;             // slow ticks into the scan period
  logic [3:0]  sel_q;                // pin being measured
  logic        run_q;
  logic        ref_q;                // reference capacitor under measurement
  logic [SENSE_CHANNELS-1:0] pull_q;

  // field views
  wire         pd_bit     = touch_ctrl_q[TC_PD_BIT];
  wire  [2:0]  time_field = touch_ctrl_q[TC_TMR_LSB +: 3];
  wire  [3:0]  chs_field  = touch_ctrl_q[TC_CHS_LSB +: 4];
  wire         auto_en    = scan_ctrl_q[SC_AUTO_BIT];
  wire         rate_bit   = scan_ctrl_q[SC_RATE_BIT];
  wire  [1:0]  num_field  = scan_ctrl_q[SC_NUM_LSB +: 2];
  wire         soc_bit    = aux_q[AUX_SOC_BIT];

  // bus write decode
  wire wr_tc   = sfr_wr_in && (sfr_addr_in == ADDR_TOUCH_CTRL);
  wire wr_sc   = sfr_wr_in && (sfr_addr_in == ADDR_SCAN_CTRL);
  wire wr_aux  = sfr_wr_in && (sfr_addr_in == ADDR_AUX_CTRL);
  wire wr_if   = sfr_wr_in && (sfr_addr_in == ADDR_INT_FLAGS);

  // measurement engine hookup
  logic        meas_busy;
  logic        meas_done;
  logic [9:0]  meas_count;
  logic        meas_ovf;

  // period end, counted on the slow clock enable
  // at or past the end: a switch to the short rate mid-count ends
  // that period at the next slow tick instead of wrapping the whole counter
  wire [12:0] period_last = rate_bit ? 13'(SCAN_SHORT - 1) : 13'(SCAN_LONG - 1); // [RULE_13]
  wire        period_hit  = slow_tick_in && (period_q >= period_last);

  // manual start only when auto is off and unit is powered
  wire soc_rise     = soc_bit && !soc_prev_q; // [RULE_04]
  wire manual_go    = soc_rise && !auto_en && !pd_bit; // [RULE_01] [RULE_03]
  wire auto_go      = auto_en && period_hit; // [RULE_12] [RULE_11]

  // auto-scan compare on the finished channel
  // 8-bit threshold: counts of 256 and up never flag a touch
  wire [7:0] cur_thresh = thresh_q[chan_q];
  wire       is_touch   = meas_count < {2'b00, cur_thresh}; // [RULE_15]
  wire       last_chan  = (chan_q == num_field); // [RULE_14]

  // leaving auto mode mid-scan drops the running window
  wire auto_abort = auto_run_q && !auto_en && (state_q != ST_IDLE);

  // start pulse towards the engine
  wire meas_start = (state_q == ST_IDLE && (auto_go || manual_go)) ||
                    (state_q == ST_GAP && !auto_abort);

  // selected pin for the next conversion
  // auto-scan only ever reaches channels 0 to 3
  wire [3:0] next_sel = (state_q == ST_GAP) ? {2'b00, chan_q + 2'd1} :
                        auto_go             ? 4'h0 :
                                              chs_field; // [RULE_10]

  // one-hot pull-up disable, reference code drives none
  function automatic logic [SENSE_CHANNELS-1:0] pin_onehot(input logic [3:0] sel);
    logic [SENSE_CHANNELS-1:0] v;
    v = '0;
    if (sel != CHS_REF_CAP) begin
      v[sel] = 1'b1;
    end
    return v;
  endfunction : pin_onehot

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (auto_go || manual_go) begin
          state_d = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (auto_abort) begin
          state_d = ST_IDLE;
        end else if (meas_done) begin
          // manual conversions skip the compare
          state_d = auto_run_q ? ST_CMP : ST_IDLE;
        end
      end
      ST_CMP: begin
        // channels follow one another inside one period
        state_d = (last_chan || auto_abort) ? ST_IDLE : ST_GAP; // [RULE_20]
      end
      ST_GAP: begin
        state_d = auto_abort ? ST_IDLE : ST_MEAS;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_q    <= ST_IDLE;
      auto_run_q <= 1'b0;
      chan_q     <= 2'd0;
      sel_q      <= 4'h0;
      run_q      <= 1'b0;
      ref_q      <= 1'b0;
      pull_q     <= '0;
    end else begin
      state_q <= state_d;
      if (meas_start) begin
        sel_q  <= next_sel;
        run_q  <= 1'b1;
        pull_q <= pin_onehot(next_sel); // [RULE_02]
        // registered so the pad switch sees no decode glitch
        ref_q  <= (next_sel == CHS_REF_CAP); // [RULE_10]
      end else if (meas_done || auto_abort) begin
        run_q  <= 1'b0;
        ref_q  <= 1'b0;
        pull_q <= '0; // pull-ups back once the pin is released
      end
      if (state_q == ST_IDLE && auto_go) begin
        auto_run_q <= 1'b1;
        chan_q     <= 2'd0;
      end else if (state_q == ST_IDLE && manual_go) begin
        auto_run_q <= 1'b0;
      end else if (state_q == ST_GAP) begin
        chan_q <= chan_q + 2'd1;
      end
    end
  end

  // scan period counter, runs only while auto-scan owns the unit
  // leaving auto mode restarts the period from zero
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      period_q <= 13'h0000;
    end else if (!auto_en) begin
      period_q <= 13'h0000;
    end else if (period_hit) begin
      period_q <= 13'h0000;
    end else if (slow_tick_in) begin
      period_q <= period_q + 13'd1;
    end
  end

  // control registers written by software
  // scan control keeps only its low nibble
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      touch_ctrl_q <= RST_TOUCH_CTRL;
      scan_ctrl_q  <= RST_SCAN_CTRL;
      for (int i = 0; i < AUTO_CHANNELS; i++) begin
        thresh_q[i] <= RST_THRESH;
      end
    end else begin
      if (wr_tc) begin
        touch_ctrl_q <= sfr_wdata_in;
      end
      if (wr_sc) begin
        scan_ctrl_q <= sfr_wdata_in[3:0];
      end
      for (int i = 0; i < AUTO_CHANNELS; i++) begin
        if (sfr_wr_in && sfr_addr_in == ADDR_THRESH_CH0 + 8'(i)) begin
          thresh_q[i] <= sfr_wdata_in;
        end
      end
    end
  end

  // start bit: software sets, hardware clears at end of a manual conversion
  // a bit left high needs a write of 0 before the next start
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      aux_q      <= RST_AUX_CTRL;
      soc_prev_q <= 1'b0;
    end else begin
      soc_prev_q <= soc_bit;
      if (wr_aux) begin
        // a software write in the same cycle as end of conversion wins
        aux_q <= sfr_wdata_in[4:0];
      end else if (meas_done && !auto_run_q) begin
        aux_q[AUX_SOC_BIT] <= 1'b0; // [RULE_04]
      end
    end
  end

  // manual result, done and overflow flags
  // auto conversions leave the manual result alone
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      done_flag_q <= RST_DONE_FLAG;
      ovf_flag_q  <= 1'b0;
      count_q     <= 10'h000;
    end else if (state_q == ST_IDLE && manual_go) begin
      done_flag_q <= 1'b0; // [RULE_05]
      ovf_flag_q  <= 1'b0;
    end else if (meas_done && !auto_run_q) begin
      done_flag_q <= 1'b1; // [RULE_05]
      ovf_flag_q  <= meas_ovf; // [RULE_08]
      count_q     <= meas_count; // [RULE_05]
    end
  end

  // auto-scan touch bits and interrupt flag
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      result_q     <= 4'h0;
      touch_flag_q <= 1'b0;
      wake_q       <= 1'b0;
    end else begin
      wake_q <= 1'b0;
      if (state_q == ST_CMP) begin
        result_q[chan_q] <= is_touch; // [RULE_16] [RULE_20]
      end
      if (state_q == ST_CMP && is_touch) begin
        // a new touch beats a clear in the same cycle
        touch_flag_q <= 1'b1; // [RULE_15] [RULE_17]
        wake_q       <= 1'b1; // [RULE_15]
      end else if (irq_ack_in) begin
        touch_flag_q <= 1'b0; // [RULE_17]
      end else if (wr_if && !sfr_wdata_in[IF_TOUCH_BIT]) begin
        touch_flag_q <= 1'b0; // [RULE_17]
      end
    end
  end

  // read mux, unmapped addresses and reserved bits read zero
  // count bytes are not latched together; read them after done
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (sfr_addr_in)
      ADDR_INT_FLAGS:   rd_mux = {4'h0, touch_flag_q, 3'b000};
      ADDR_SCAN_STATUS: rd_mux = {done_flag_q, ovf_flag_q, count_q[9:8], result_q};
      ADDR_COUNT_LOW:   rd_mux = count_q[7:0];
      ADDR_TOUCH_CTRL:  rd_mux = touch_ctrl_q;
      ADDR_SCAN_CTRL:   rd_mux = {4'h0, scan_ctrl_q};
      ADDR_THRESH_CH0:  rd_mux = thresh_q[0];
      ADDR_THRESH_CH1:  rd_mux = thresh_q[1];
      ADDR_THRESH_CH2:  rd_mux = thresh_q[2];
      ADDR_THRESH_CH3:  rd_mux = thresh_q[3];
      ADDR_AUX_CTRL:    rd_mux = {3'b000, aux_q};
      default:          rd_mux = 8'h00;
    endcase
  end

  // read data registered, answer one cycle after the strobe
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd_in) begin
      rdata_q <= rd_mux;
    end
  end

  // conversion engine
  tks_meas u_meas (
    .sys_clk_in   (sys_clk_in),
    .rst_n_in     (rst_n_in),
    .start_in     (meas_start),
    .abort_in     (auto_abort),
    .time_sel_in  (time_field), // [RULE_09]
    .osc_pulse_in (sense_osc_pulse_in),
    .busy_out     (meas_busy),
    .done_out     (meas_done),
    .count_out    (meas_count),
    .ovf_out      (meas_ovf)
  );

  // outputs straight from flops
  assign sfr_rdata_out   = rdata_q;
  assign sense_sel_out   = sel_q;
  assign ref_cap_sel_out = ref_q;
  assign sense_run_out   = run_q;
  assign pullup_off_out  = pull_q;
  assign touch_irq_out   = touch_flag_q;
  assign wake_out        = wake_q;
  assign aux_misc_out    = aux_q[3:0];

  // engine busy is mirrored by run_q; kept for visibility only
  logic unused_busy;
  assign unused_busy = meas_busy;

endmodule : tks_ctrl

// ### tb/tks_ctrl_chk.sv
// watches the touch unit's ports; attached by bind from the bench
module tks_ctrl_chk
  import tks_pkg::*;
#(
  parameter int SCAN_LONG  = 8,
  parameter int SCAN_SHORT = 4
) (
  input wire logic        sys_clk_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  sfr_addr_in,
  input wire logic        sfr_wr_in,
  input wire logic [7:0]  sfr_wdata_in,
  input wire logic        irq_ack_in,
  input wire logic [3:0]  sense_sel_out,
  input wire logic        ref_cap_sel_out,
  input wire logic        sense_run_out,
  input wire logic [14:0] pullup_off_out,
  input wire logic        touch_irq_out,
  input wire logic        wake_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic [11:0] run_len_q;  // cycles spent in the current conversion
  // saturating, so a stuck window cannot wrap back under the bound
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || !sense_run_out) run_len_q <= 12'h000;
    else if (run_len_q != 12'hfff) run_len_q <= run_len_q + 12'h001;
  end
  a_pullup_sel: assert property (
    sense_run_out && sense_sel_out != 4'hf |-> pullup_off_out == (15'h0001 << sense_sel_out))
    else $error("pull-up release does not match measured pin");
  a_pullup_idle: assert property (
    !sense_run_out || sense_sel_out == 4'hf |-> pullup_off_out == 15'h0000)
    else $error("pull-up released while no pad is measured");
  a_ref_cap_sel: assert property (
    ref_cap_sel_out == (sense_run_out && sense_sel_out == CHS_REF_CAP))
    else $error("reference capacitor select wrong");
  a_wake_flag: assert property (wake_out |-> touch_irq_out)
    else $error("wake without touch flag");
  a_wake_single: assert property (wake_out |=> !wake_out)
    else $error("wake pulse longer than one cycle");
  a_flag_cause: assert property ($rose(touch_irq_out) |-> wake_out)
    else $error("touch flag set without a detected touch");
  a_ack_clear: assert property (irq_ack_in |=> !touch_irq_out || wake_out)
    else $error("service entry did not clear touch flag");
  a_soft_clear: assert property (
    sfr_wr_in && sfr_addr_in == ADDR_INT_FLAGS && !sfr_wdata_in[IF_TOUCH_BIT]
    |=> !touch_irq_out || wake_out)
    else $error("flag write did not clear touch flag");
  a_sel_steady: assert property (sense_run_out [*2] |-> $stable(sense_sel_out))
    else $error("channel changed inside a conversion");
  a_run_bounded: assert property (run_len_q <= 12'h808)
    else $error("conversion longer than the longest window");
  c_wake: cover property (wake_out);
  c_ref_cap: cover property (ref_cap_sel_out);
  c_long_window: cover property (run_len_q == 12'h800);
endmodule : tks_ctrl_chk

// ### tb/tks_pad_model.sv
// sense pads: oscillator pulses only while a pad is being measured
module tks_pad_model (
  input  wire logic        clk_in,
  input  wire logic [3:0]  sel_in,
  input  wire logic        run_in,
  input  wire logic [14:0] touched_in,
  input  wire logic        fast_in,
  output logic             osc_pulse_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase_q;  // position inside one oscillation
  logic [2:0] period;   // cycles per oscillation
  // a finger adds capacitance and slows the pad; fast pulses every cycle and overflows time codes 3 and up
  assign period = fast_in ? 3'h1 : (sel_in == 4'hf) ? 3'h3 :
                  touched_in[sel_in] ? 3'h4 : 3'h2;
  assign osc_pulse_out = run_in && (phase_q + 3'h1 >= period);
  // pad stands still outside a measurement
  always_ff @(posedge clk_in) begin
    if (!run_in || osc_pulse_out) phase_q <= 3'h0;
    else phase_q <= phase_q + 3'h1;
  end
endmodule : tks_pad_model

// ### tb/touch_key_scan_controller_bench.sv
module touch_key_scan_controller_bench;
  import tks_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic        wr_s;
  logic        rd_s;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        tick = 1'b0;
  logic [7:0]  tick_cnt = 8'h00;  // one slow tick per 256 cycles
  logic        ack;
  logic        osc;
  logic [3:0]  sel;
  logic        refc;
  logic        run;
  logic [14:0] pull;
  logic        irq;
  logic        wake;
  logic [3:0]  aux;
  logic [14:0] touched;
  logic        fast;
  logic [15:0] seen = 16'h0;  // channels measured since last clear
  logic        run_d = 1'b0;
  int          cyc = 0;
  int          t_prev = 0;
  int          t_last = 0;
  int          n_mismatch = 0;
  int          comparisons = 0;
  logic [7:0]  st;
  logic [7:0]  lo;
  logic [9:0]  cu;
  logic [9:0]  cx;
  int          n;
  // rows: {write, address, write data, expected read}
  logic [24:0] rows [0:21] = '{25'h0ad00cf, 25'h0ae0003, 25'h0c40040, 25'h0c50040,
    25'h0c60040, 25'h0c70040, 25'h0f80000, 25'h0950000, 25'h0ab0080, 25'h0ac0000,
    25'h0800000, 25'h1c4a5a5, 25'h1c55a5a, 25'h1c6ffff, 25'h1c70000, 25'h1aef000,
    25'h1805500, 25'h1ad3f3f, 25'h1c44040, 25'h1c55050, 25'h1c64040, 25'h1f80f0f};

  tks_ctrl #(.SCAN_LONG(8), .SCAN_SHORT(4)) dut (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n), .sfr_addr_in(addr), .sfr_wr_in(wr_s),
    .sfr_rd_in(rd_s), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
    .slow_tick_in(tick), .irq_ack_in(ack), .sense_osc_pulse_in(osc),
    .sense_sel_out(sel), .ref_cap_sel_out(refc), .sense_run_out(run),
    .pullup_off_out(pull), .touch_irq_out(irq), .wake_out(wake), .aux_misc_out(aux));
  tks_pad_model pads (.clk_in(sys_clk), .sel_in(sel), .run_in(run),
    .touched_in(touched), .fast_in(fast), .osc_pulse_out(osc));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // slow clock enable from a free divider
  always @(posedge sys_clk) begin
    tick_cnt <= tick_cnt + 8'h01;
    tick <= (tick_cnt == 8'hff);
  end
  // records measured channels and start times of conversions
  always @(negedge sys_clk) begin
    cyc++;
    if (run === 1'b1) seen |= 16'h1 << sel;
    if (run === 1'b1 && !run_d) begin
      t_prev = t_last;
      t_last = cyc;
    end
    run_d = (run === 1'b1);
  end
  task automatic chk(input string name, input logic [31:0] seen_v, input logic [31:0] exp);
    comparisons++;
    if (seen_v !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen_v);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask : rd
  // one manual conversion; returns status byte and low count byte
  task automatic conv(input logic [3:0] chs, input logic [2:0] tmr,
                      output logic [7:0] s, output logic [7:0] l);
    int k;
    wr(ADDR_TOUCH_CTRL, {1'b0, tmr, chs});
    wr(ADDR_AUX_CTRL, 8'h10);
    for (k = 0; k < 20 && run !== 1'b1; k++) @(negedge sys_clk);
    chk("pullup", 32'(pull), (chs == 4'hf) ? 32'h0 : 32'h1 << chs);
    chk("refcap", 32'(refc), 32'(chs == 4'hf));
    rd(ADDR_SCAN_STATUS, s);
    chk("done_low", 32'(s[7]), 32'h0);
    for (k = 0; k < 3000 && run !== 1'b0; k++) @(negedge sys_clk);
    repeat (4) @(posedge sys_clk);
    rd(ADDR_AUX_CTRL, l);
    chk("start_cleared", 32'(l[AUX_SOC_BIT]), 32'h0);
    rd(ADDR_COUNT_LOW, l);
    rd(ADDR_SCAN_STATUS, s);
    chk("done_high", 32'(s[7]), 32'h1);
    repeat (2500) @(posedge sys_clk);
  endtask : conv
  task automatic complete_run;
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    {rst_n, addr, wr_s, rd_s, wdata, ack, touched, fast} = '0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values, access kinds, reserved and unmapped places
    foreach (rows[i]) begin
      if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], st);
      chk("register", 32'(st), 32'(rows[i][7:0]));
    end
    chk("aux_bits", 32'(aux), 32'hf);
    wr(ADDR_AUX_CTRL, 8'h00);
    // manual conversions: count, touch, window, reference, edge channel
    conv(4'h5, 3'h0, st, lo);
    cu = {st[5:4], lo};
    chk("untouched", 32'(cu >= 10'd120 && cu <= 10'd136), 32'h1);
    touched = 15'h0020;
    conv(4'h5, 3'h0, st, lo);
    chk("touched_less", 32'({st[5:4], lo} < cu), 32'h1);
    touched = 15'h0;
    conv(4'h5, 3'h1, st, lo);
    cx = {st[5:4], lo};
    chk("window_x2", 32'(cx >= 2 * cu - 4 && cx <= 2 * cu + 4), 32'h1);
    conv(4'hf, 3'h0, st, lo);
    chk("ref_count", 32'({st[5:4], lo} > 10'd70 && {st[5:4], lo} < 10'd100), 32'h1);
    conv(4'he, 3'h0, st, lo);
    fast = 1'b1;
    conv(4'h0, 3'h7, st, lo);
    chk("ovf_set", 32'({st[6:4], lo}), 32'h7ff);
    fast = 1'b0;
    conv(4'h0, 3'h0, st, lo);
    chk("ovf_clear", 32'(st[6]), 32'h0);
    // powered down: a start edge is ignored
    wr(ADDR_TOUCH_CTRL, 8'h85);
    wr(ADDR_AUX_CTRL, 8'h10);
    repeat (20) @(negedge sys_clk);
    chk("pd_refused", 32'(run), 32'h0);
    wr(ADDR_AUX_CTRL, 8'h00);
    // auto scan, every channel-count code; pad 1 touched below its threshold
    touched = 15'h0002;
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_SCAN_CTRL, 8'h08 | 8'(c));
      seen = 16'h0;
      repeat (3200) @(posedge sys_clk);
      chk("auto_chans", 32'(seen), (32'h2 << c) - 32'h1);
    end
    rd(ADDR_SCAN_STATUS, st);
    chk("result", 32'(st[3:0]), 32'h2);
    chk("flag_set", 32'(irq), 32'h1);
    rd(ADDR_INT_FLAGS, st);
    chk("flag_read", 32'(st), 32'h08);
    for (n = 0; n < 3000 && wake !== 1'b1; n++) @(negedge sys_clk);
    chk("wake_seen", 32'(wake), 32'h1);
    @(posedge sys_clk);
    ack <= 1'b1;
    @(posedge sys_clk);
    ack <= 1'b0;
    @(negedge sys_clk);
    chk("ack_clear", 32'(irq), 32'h0);
    for (n = 0; n < 3000 && wake !== 1'b1; n++) @(negedge sys_clk);
    chk("wake_again", 32'(wake), 32'h1);
    wr(ADDR_INT_FLAGS, 8'hf7);
    @(negedge sys_clk);
    chk("f7_clear", 32'(irq), 32'h0);
    // scan period for both rate settings, channel 0 only
    touched = 15'h0;
    wr(ADDR_SCAN_CTRL, 8'h0c);
    repeat (3500) @(posedge sys_clk);
    chk("rate_short", 32'(t_last - t_prev), 32'd1024);
    wr(ADDR_SCAN_CTRL, 8'h08);
    repeat (5000) @(posedge sys_clk);
    chk("rate_long", 32'(t_last - t_prev), 32'd2048);
    wr(ADDR_SCAN_CTRL, 8'h03);
    // reset in mid conversion
    conv(4'h2, 3'h0, st, lo);
    wr(ADDR_AUX_CTRL, 8'h10);
    repeat (50) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk("reset_run", 32'(run), 32'h0);
    rd(ADDR_SCAN_STATUS, st);
    chk("reset_done", 32'(st), 32'h80);
    complete_run();
  end
endmodule : touch_key_scan_controller_bench

bind tks_ctrl tks_ctrl_chk #(.SCAN_LONG(SCAN_LONG), .SCAN_SHORT(SCAN_SHORT)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .sfr_addr_in(sfr_addr_in),
  .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .irq_ack_in(irq_ack_in),
  .sense_sel_out(sense_sel_out), .ref_cap_sel_out(ref_cap_sel_out),
  .sense_run_out(sense_run_out), .pullup_off_out(pullup_off_out),
  .touch_irq_out(touch_irq_out), .wake_out(wake_out));
